// ---- dv/scsf_card.sv ----
// Card side model: received characters and the error line
`timescale 1ns/100ps
module scsf_card (
  input wire clk_i,
  input wire send_i,
  input wire [7:0] data_i,
  input wire flag_i,
  output logic rx_done_o,
  output logic [7:0] rx_data_o,
  output wire err_pin_o
);
  always @(posedge clk_i)
  begin
    rx_done_o <= send_i;
    rx_data_o <= send_i ? data_i : ~rx_data_o;
  end
  // Pulled-up line, low for an error
  assign err_pin_o = !flag_i;
endmodule // scsf_card

// ---- dv/scsf_status_props.sv ----
// Port checker for the smart card status flag block
`timescale 1ns/100ps
module scsf_status_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rx_done_i,
  input wire rx_ok_i,
  input wire tx_dma_write_i,
  input wire rx_dma_read_i,
  input wire tx_buffer_request_o,
  input wire rx_buffer_request_o,
  input wire transmitter_enable_bit_o,
  input wire receiver_enable_bit_o,
  input wire rx_allow_o,
  input wire [7:0] rx_holding_register_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_txdma; tx_dma_write_i && tx_buffer_request_o ##1 transmitter_enable_bit_o; endsequence
  sequence s_late; rx_allow_o && rx_done_i && rx_ok_i && rx_buffer_request_o && !rx_dma_read_i; endsequence
  a_ack_after_req: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_tx_dma_clear: assert property (s_txdma |-> !tx_buffer_request_o) else $error("tx req");
  a_rx_dma_clear: assert property (rx_dma_read_i && !rx_done_i && rx_buffer_request_o
    |=> !rx_buffer_request_o) else $error("rx req");
  a_overrun_keep: assert property (s_late |=> $stable(rx_holding_register_o)) else $error("data");
  a_overrun_stop: assert property (s_late |=> !rx_allow_o) else $error("rx on");
  a_allow_needs_re: assert property (rx_allow_o |-> receiver_enable_bit_o) else $error("re");
  a_re_off_keeps: assert property ($fell(receiver_enable_bit_o)
    && !$past(rx_done_i || rx_dma_read_i)
    |-> $stable(rx_buffer_request_o)) else $error("full lost");
endmodule // scsf_status_props
bind scsf_status scsf_status_props chk (.*);

// ---- dv/tb.sv ----
// Self-checking bench for the status flag block
`timescale 1ns/100ps
module tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, sync_mode_i = 0, send = 0;
  logic tx_load_i = 0, tx_dma_write_i = 0, rx_dma_read_i = 0, err_sample_i = 0, flag = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0, seed = 32'h1ddd4e45;
  logic [7:0] b = 0, prev = 0;
  wire [31:0] wb_dat_o;
  wire [7:0] rx_data_i, rx_holding_register_o;
  wire wb_ack_o, rx_done_i, err_pin_i, tx_buffer_request_o, rx_buffer_request_o, rx_allow_o;
  wire transmitter_enable_bit_o, receiver_enable_bit_o, tx_allow_o, rx_ok_i = 1'b1;
  int err_total = 0, samples_checked = 0;
  logic [15:0] ops [$] = {16'h1080, 16'h1c00, 16'h0801, 16'h0430, 16'h1080, 16'h0000, 16'h1000,
    16'h2010, 16'h1080, 16'h0080, 16'h1080, 16'h2008, 16'h1000, 16'h3000, 16'h7000, 16'h1040,
    16'h6300, 16'h2004, 16'h1000, 16'h3000, 16'h7001, 16'h3000, 16'h1060, 16'h6000, 16'h0420,
    16'h1060, 16'h0000, 16'h1000, 16'h0430, 16'h4001, 16'h2000, 16'h2000, 16'h2002, 16'h4000,
    16'h1010, 16'h0000, 16'h1000, 16'h0400, 16'h1080, 16'h0800, 16'h3000, 16'h1080};
  scsf_status dut (.*);
  scsf_card card (.clk_i, .send_i(send), .data_i(b), .flag_i(flag), .rx_done_o(rx_done_i),
    .rx_data_o(rx_data_i), .err_pin_o(err_pin_i));
  always #5 clk_i = ~clk_i;
  task close_out;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [9:0] g, input logic [9:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
      @(posedge clk_i);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (!w)
      chk(wb_dat_o[7:0], d);
    if (n == 20)
    begin
      chk(0, 1);
      close_out;
    end
  endtask
  task ev(input logic [4:0] v);
    @(posedge clk_i);
    {tx_load_i, tx_dma_write_i, rx_dma_read_i, err_sample_i, send} <= v;
    @(posedge clk_i);
    {tx_load_i, tx_dma_write_i, rx_dma_read_i, err_sample_i, send} <= 5'h00;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    foreach (ops[i])
    begin
      case (ops[i][15:12])
        0, 1: wb(!ops[i][12], ops[i][11:8], ops[i][7:0]);
        2: ev(ops[i][4:0]);
        3:
        begin
          seed ^= seed << 13;
          seed ^= seed >> 17;
          seed ^= seed << 5;
          b <= seed[7:0];
          ev(5'h01);
        end
        4: flag <= ops[i][0];
        6:
        begin
          #1;
          chk({rx_allow_o, tx_allow_o, rx_holding_register_o}, {ops[i][9:8], prev});
        end
        default:
        begin
          prev = b;
          sync_mode_i <= ops[i][0];
        end
      endcase
    end
    close_out;
  end
endmodule // tb

// ---- inc/scsf_regs.vh ----
// Register map and field constants for the smart card status flag block
`ifndef SCSF_REGS_VH
`define SCSF_REGS_VH
// Byte offsets on the Wishbone bus
`define SCSF_STATUS_OFS 4'h0
`define SCSF_CTRL_OFS 4'h4
`define SCSF_MODE_OFS 4'h8
// Status register fields
`define SCSF_TXE_POS 7
`define SCSF_RXF_POS 6
`define SCSF_OVR_POS 5
`define SCSF_CERR_POS 4
// Control register fields
`define SCSF_TXEN_POS 5
`define SCSF_RXEN_POS 4
// Mode register fields
`define SCSF_CARD_SEL_POS 0
// Reset values
`define SCSF_STATUS_RST 8'h80
`define SCSF_CTRL_RST 8'h00
`define SCSF_MODE_RST 8'h00
`endif

// ---- rtl/scsf_status.v ----
// Smart card mode serial status flags with Wishbone register slave
`timescale 1ns/100ps
`include "scsf_regs.vh"

module scsf_status (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire tx_load_i,
  input wire rx_done_i,
  input wire rx_ok_i,
  input wire [7:0] rx_data_i,
  input wire err_pin_i,
  input wire err_sample_i,
  input wire tx_dma_write_i,
  input wire rx_dma_read_i,
  input wire sync_mode_i,
  output wire tx_buffer_request_o,
  output wire rx_buffer_request_o,
  output wire transmitter_enable_bit_o,
  output wire receiver_enable_bit_o,
  output wire rx_allow_o,
  output wire tx_allow_o,
  output reg [7:0] rx_holding_register_o
);

  // ****************************************
  // Declarations
  // ****************************************
  reg tx_holding_empty_flag;
  reg rx_holding_full_flag;
  reg rx_overrun_flag;
  reg card_error_signal_flag;
  reg next_tx_holding_empty_flag;
  reg next_rx_holding_full_flag;
  reg next_rx_overrun_flag;
  reg next_card_error_signal_flag;
  reg [7:0] next_rx_holding_register;
  reg [7:0] serial_control_register;
  reg [7:0] smartcard_mode_register;
  reg [7:0] next_serial_control_register;
  reg [7:0] next_smartcard_mode_register;
  reg [31:0] next_wb_dat;
  reg [2:0] err_sync;
  reg err_level;
  wire bus_req;
  wire bus_rd;
  wire bus_wr;
  wire adr_status;
  wire adr_ctrl;
  wire adr_mode;
  wire rd_stat;
  wire wr_stat;
  wire wr_ctrl;
  wire wr_mode;
  wire card_sel;
  wire tx_en;
  wire rx_en;
  wire err_low;
  wire accept_rx;
  wire good_rx;
  wire late_rx;
  wire [3:0] flag_vec;
  wire [3:0] wr_bits;
  wire [3:0] seen_one;
  wire [3:0] clr_req;
  wire [7:0] status_byte;

  // ****************************************
  // Bus decode
  // ****************************************
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_rd = bus_req & ~wb_we_i;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign adr_status = (wb_adr_i == `SCSF_STATUS_OFS);
  assign adr_ctrl = (wb_adr_i == `SCSF_CTRL_OFS);
  assign adr_mode = (wb_adr_i == `SCSF_MODE_OFS);
  assign rd_stat = bus_rd & adr_status;
  assign wr_stat = bus_wr & adr_status;
  assign wr_ctrl = bus_wr & adr_ctrl;
  assign wr_mode = bus_wr & adr_mode;

  // ****************************************
  // Control bits and status byte
  // ****************************************
  assign card_sel = smartcard_mode_register[`SCSF_CARD_SEL_POS];
  assign tx_en = serial_control_register[`SCSF_TXEN_POS];
  assign rx_en = serial_control_register[`SCSF_RXEN_POS];
  assign flag_vec = {tx_holding_empty_flag,
                     rx_holding_full_flag,
                     rx_overrun_flag,
                     card_error_signal_flag};
  assign status_byte = {flag_vec, 4'h0};
  assign wr_bits = {wb_dat_i[`SCSF_TXE_POS],
                    wb_dat_i[`SCSF_RXF_POS],
                    wb_dat_i[`SCSF_OVR_POS],
                    wb_dat_i[`SCSF_CERR_POS]};

  // ****************************************
  // Outputs to the rest of the channel
  // ****************************************
  assign transmitter_enable_bit_o = tx_en;
  assign receiver_enable_bit_o = rx_en;
  assign tx_buffer_request_o = card_sel & tx_en & tx_holding_empty_flag;
  assign rx_buffer_request_o = card_sel & rx_holding_full_flag;
  assign rx_allow_o = rx_en & ~rx_overrun_flag;
  assign tx_allow_o = tx_en & ~(sync_mode_i & rx_overrun_flag);

  // ****************************************
  // Reception qualifiers
  // ****************************************
  // Overrun blocks any further reception
  assign accept_rx = card_sel & rx_en & rx_done_i & ~rx_overrun_flag;
  assign good_rx = accept_rx & rx_ok_i & ~rx_holding_full_flag;
  assign late_rx = accept_rx & rx_holding_full_flag;

  // ****************************************
  // Wishbone slave: one registered ack per request, a cycle after the strobe
  // ****************************************
  always @*
  begin
    next_wb_dat = wb_dat_o;
    if (bus_rd)
    begin
      case (wb_adr_i)
        `SCSF_STATUS_OFS: next_wb_dat = {24'h000000, status_byte};
        `SCSF_CTRL_OFS: next_wb_dat = {24'h000000, serial_control_register};
        `SCSF_MODE_OFS: next_wb_dat = {24'h000000, smartcard_mode_register};
        default: next_wb_dat = 32'h00000000;
      endcase
    end
  end

  always @*
  begin
    next_serial_control_register = serial_control_register;
    next_smartcard_mode_register = smartcard_mode_register;
    if (wr_ctrl)
      next_serial_control_register = wb_dat_i[7:0];
    if (wr_mode)
      next_smartcard_mode_register = wb_dat_i[7:0];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      serial_control_register <= `SCSF_CTRL_RST;
      smartcard_mode_register <= `SCSF_MODE_RST;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= next_wb_dat;
      serial_control_register <= next_serial_control_register;
      smartcard_mode_register <= next_smartcard_mode_register;
    end
  end

  // ****************************************
  // Error pin synchroniser
  // ****************************************
  // Idle line is high, so reset to high avoids a false error
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      err_sync <= 3'h7;
      err_level <= 1'b1;
    end
    else
    begin
      err_sync <= {err_sync[1:0], err_pin_i};
      if (err_sync[1] == err_sync[2])
        err_level <= err_sync[2];
    end
  end

  assign err_low = err_sample_i & ~err_level;

  // ****************************************
  // Read-as-one memory per flag
  // ****************************************
  // A status write consumes the memory, so each clear needs a fresh read
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_flag_mem
      reg seen;
      always @(posedge clk_i)
      begin
        if (rst_i)
          seen <= 1'b0;
        else if (rd_stat)
          seen <= flag_vec[gi];
        else if (wr_stat)
          seen <= 1'b0;
      end
      assign seen_one[gi] = seen;
      assign clr_req[gi] = wr_stat & ~wr_bits[gi] & seen;
    end
  endgenerate

  // ****************************************
  // Next flag values; hardware set wins over clear
  // ****************************************
  always @*
  begin
    next_tx_holding_empty_flag = tx_holding_empty_flag;
    if (card_sel)
    begin
      if (~tx_en)
        next_tx_holding_empty_flag = 1'b1;
      else if (tx_load_i)
        next_tx_holding_empty_flag = 1'b1;
      else if (clr_req[3])
        next_tx_holding_empty_flag = 1'b0;
      else if (tx_dma_write_i)
        next_tx_holding_empty_flag = 1'b0;
    end
  end

  always @*
  begin
    // Receiver enable gates only the set, through good_rx; the clears ignore it
    next_rx_holding_full_flag = rx_holding_full_flag;
    next_rx_holding_register = rx_holding_register_o;
    if (card_sel)
    begin
      if (good_rx)
      begin
        next_rx_holding_full_flag = 1'b1;
        next_rx_holding_register = rx_data_i;
      end
      else if (clr_req[2])
        next_rx_holding_full_flag = 1'b0;
      else if (rx_dma_read_i)
        next_rx_holding_full_flag = 1'b0;
    end
  end

  always @*
  begin
    next_rx_overrun_flag = rx_overrun_flag;
    if (card_sel)
    begin
      // Holding register keeps older data on overrun
      if (late_rx)
        next_rx_overrun_flag = 1'b1;
      else if (clr_req[1])
        next_rx_overrun_flag = 1'b0;
    end
  end

  always @*
  begin
    next_card_error_signal_flag = card_error_signal_flag;
    if (card_sel)
    begin
      if (err_low)
        next_card_error_signal_flag = 1'b1;
      else if (clr_req[0])
        next_card_error_signal_flag = 1'b0;
    end
  end

  // ****************************************
  // Flag registers
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_holding_empty_flag <= 1'b1;
      rx_holding_full_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      card_error_signal_flag <= 1'b0;
      rx_holding_register_o <= 8'h00;
    end
    else
    begin
      tx_holding_empty_flag <= next_tx_holding_empty_flag;
      rx_holding_full_flag <= next_rx_holding_full_flag;
      rx_overrun_flag <= next_rx_overrun_flag;
      card_error_signal_flag <= next_card_error_signal_flag;
      rx_holding_register_o <= next_rx_holding_register;
    end
  end

endmodule // scsf_status
